// ### rtl/sfcp_core.sv
// Function
// [R01] 4 Mbit: code 0 none, 1..6 lower 63/64..1/2, 7 whole array.
// [R02] 2 Mbit: code 0 none, 1..5 lower 31/32..1/2, 11x whole array.
// [R03] Page program stores up to 256 bytes, wraps within page, clears only.
// [R04] Host sends write enable, then opcode, three address and data bytes.
// [R05] Sector, block or chip erase sets its scope to FF, starts cycle.
// [R06] In-progress bit is visible to status reads for polling.
// [R07] Active while selected or busy, standby once cycle ends.
// [R08] Deep sleep entered by its command, left only by wake command.
// [R09] Deep sleep ignores every command but wake.
// [R10] Command starts at select fall; first byte is the opcode.
// [R11] Input sampled on rising clock, most significant bit first.
// [R12] Command ends at select rise; reads may stop at any bit.
// [R13] Writing commands ending off a byte boundary are discarded.
// [R14] During a cycle only read status is served.
// [R15] 06 sets, 04 clears latch; 05 returns status byte.
// [R16] Status byte repeats, refreshed each time, until select rises.
// [R17] 02 takes address then data; 01 takes one status byte.
// [R18] 20 sector, 52 and D8 block erase with address; C7, 60 chip.
// [R19] Unique ID read: address, dummy byte, then 64 bits out.
// [R20] 03 read streams data right after address, no dummy.
// [R21] 0B and 3B take address and one dummy byte before data.
// [R22] Returned bytes go out MSB first on the output line.
// [R23] Dual read: even bits on line zero, odd on line one.
// [R24] Writing commands need the latch; latch clear after reset.
// [R25] Status bit zero set during a cycle, cleared at its end.
// [R26] Protected region blocks program and erase.
// [R27] Protected program or erase is dropped without any cycle.
`timescale 1ns/1ps
`default_nettype none

module sfcp_core #(
  parameter bit IS_4MBIT = 1'b1,
  parameter int BUSY_CYCLES = 1000,
  // Arbitrary identifier value
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic serialClk,
  input wire logic chipSelN,
  input wire logic serialIn,
  output logic dualLineZeroOut,
  output logic dualLineZeroOe,
  output logic dualLineOne,
  output logic dualLineOneOe,
  output logic [23:0] rdAddr,
  input wire logic [7:0] rdData,
  output logic progStrobe,
  output logic [23:0] progAddr,
  output logic [7:0] progData,
  output logic eraseStrobe,
  output logic [23:0] eraseAddr,
  output sfcp_pkg::sfcp_erase_t eraseScope,
  output logic inProgressFlag,
  output logic writeEnableLatch,
  output logic [2:0] protectCode,
  output logic deepSleep,
  output logic deviceActive
);
  import sfcp_pkg::*;

  if (BUSY_CYCLES <= 256 || BUSY_CYCLES > 65535) begin : g_chk
    $error("BUSY_CYCLES must lie in 257..65535");
  end

  localparam logic [15:0] BUSY_LOAD = 16'(BUSY_CYCLES);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic isProt(input logic [2:0] code,
                                  input logic [23:0] a);
    logic [23:0] size;
    logic [23:0] top;
    logic [2:0] sh;
    size = IS_4MBIT ? ARRAY_BYTES_4M : ARRAY_BYTES_2M;
    sh = IS_4MBIT ? 3'h7 - code : 3'h6 - code;
    top = size - (size >> sh);
    if (code == 3'h0) begin
      top = 24'h00_0000;
    // [R01] all for 111
    end else if (IS_4MBIT && code == 3'h7) begin
      top = size;
    // [R02] all for 11x
    end else if (!IS_4MBIT && code[2:1] == 2'b11) begin
      top = size;
    end
    isProt = (a & (size - 24'h00_0001)) < top;
  endfunction

  function automatic logic [6:0] hdrBits(input logic [7:0] op);
    case (op)
      OP_READ_STATUS: hdrBits = HDR_OPCODE;
      OP_READ: hdrBits = HDR_ADDR;
      // [R21] dummy byte follows address
      OP_FAST_READ, OP_DUAL_READ, OP_UNIQUE_ID: hdrBits = HDR_DUMMY;
      default: hdrBits = 7'h00;
    endcase
  endfunction

  // ****************************************
  // Link side, on the serial clock
  // ****************************************
  typedef struct packed {
    logic tgl;
    logic din;
    logic [6:0] cnt;
    logic [7:0] op;
    logic [23:0] adr;
    logic on;
    logic dual;
    logic [2:0] pos;
    logic [7:0] cur;
    logic [23:0] ptr;
    logic [1:0] out;
    logic [7:0] stA;
    logic [7:0] stB;
    logic [1:0] okA;
    logic [1:0] okB;
    logic [7:0] stC;
    logic [7:0] stV;
    logic [1:0] okC;
    logic [1:0] okV;
  } sfcp_link_t;

  typedef struct packed {
    logic [2:0] csS;
    logic csHigh;
    logic [3:0] tgS;
    logic tgPrev;
    logic skip;
    logic [2:0] bitIdx;
    logic [9:0] byteCnt;
    logic [7:0] shf;
    logic [7:0] opc;
    logic [23:0] adr;
    logic [7:0] dat;
    logic [8:0] pgCnt;
    sfcp_mode_t mode;
    sfcp_job_t job;
    logic [15:0] busyCnt;
    logic [8:0] step;
    logic write_enable_latch;
    logic [2:0] bp;
    logic srp;
    logic progStb;
    logic [23:0] progAdr;
    logic [7:0] progDat;
    logic erStb;
    logic [23:0] erAdr;
    sfcp_erase_t erKind;
  } sfcp_sys_t;

  sfcp_link_t lk_r, lk_nxt;
  sfcp_sys_t s_r, s_nxt;
  logic [7:0] pgBuf [256];
  logic [7:0] statusWord;
  logic readOk;
  logic statusOk;
  logic start;
  logic isStat;
  logic dual;
  logic [6:0] hdr;
  logic [2:0] pp;
  logic [23:0] p;
  logic [7:0] src;
  logic [7:0] b;

  always_comb begin
    lk_nxt = lk_r;
    // [R11] rising edge, MSB first
    lk_nxt.tgl = ~lk_r.tgl;
    lk_nxt.din = serialIn;
    if (lk_r.cnt != CNT_SAT) begin
      lk_nxt.cnt = lk_r.cnt + 7'h01;
    end
    // [R10] first byte is opcode
    if (lk_r.cnt < HDR_OPCODE) begin
      lk_nxt.op = {lk_r.op[6:0], serialIn};
    end else if (lk_r.cnt < HDR_ADDR) begin
      lk_nxt.adr = {lk_r.adr[22:0], serialIn};
    end
    lk_nxt.stA = statusWord;
    lk_nxt.stB = lk_r.stA;
    lk_nxt.okA = {readOk, statusOk};
    lk_nxt.okB = lk_r.okA;
    lk_nxt.stC = lk_r.stB;
    lk_nxt.okC = lk_r.okB;
    // Taken once second and third stage agree
    if (lk_r.stB == lk_r.stC) begin
      lk_nxt.stV = lk_r.stC;
    end
    if (lk_r.okB == lk_r.okC) begin
      lk_nxt.okV = lk_r.okC;
    end
    hdr = hdrBits(lk_nxt.op);
    isStat = lk_nxt.op == OP_READ_STATUS;
    // [R14] only status while busy
    start = !lk_r.on && hdr != 7'h00 && lk_nxt.cnt == hdr &&
            (isStat ? lk_r.okV[0] : lk_r.okV[1]);
    dual = start ? lk_nxt.op == OP_DUAL_READ : lk_r.dual;
    pp = start ? 3'h7 : lk_r.pos;
    p = lk_r.ptr;
    // [R20] read data follows address
    if (start) begin
      p = (isStat || lk_nxt.op == OP_UNIQUE_ID) ? 24'h00_0000 : lk_nxt.adr;
    end
    case (lk_nxt.op)
      // [R16] status refreshed per byte
      OP_READ_STATUS: src = lk_r.stV;
      // [R19] 64-bit identifier
      OP_UNIQUE_ID: src = 8'(UNIQUE_ID >> {3'h7 - p[2:0], 3'b000});
      default: src = rdData;
    endcase
    b = (pp == 3'h7) ? src : lk_r.cur;
    if (start || lk_r.on) begin
      lk_nxt.on = 1'b1;
      lk_nxt.dual = dual;
      lk_nxt.cur = b;
      // [R23] odd on one, even on zero
      lk_nxt.out = {b[pp], dual ? b[pp - 3'h1] : 1'b0};
      if (pp == (dual ? 3'h1 : 3'h0)) begin
        lk_nxt.pos = 3'h7;
        lk_nxt.ptr = p + 24'h00_0001;
      end else begin
        lk_nxt.pos = pp - (dual ? 3'h2 : 3'h1);
        lk_nxt.ptr = p;
      end
    end
    rdAddr = p;
  end

  // [R12] select high ends any frame
  always_ff @(posedge serialClk or posedge chipSelN) begin
    if (chipSelN) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // [R22] output changes on falling edge
  always_ff @(negedge serialClk or posedge chipSelN) begin
    if (chipSelN) begin
      dualLineOne <= 1'b0;
      dualLineOneOe <= 1'b0;
      dualLineZeroOut <= 1'b0;
      dualLineZeroOe <= 1'b0;
    end else begin
      dualLineOne <= lk_r.out[1];
      dualLineOneOe <= lk_r.on;
      dualLineZeroOut <= lk_r.out[0];
      dualLineZeroOe <= lk_r.on && lk_r.dual;
    end
  end

  // ****************************************
  // System side
  // ****************************************
  logic csNew;
  logic bitEv;
  logic frameEnd;
  logic good;
  logic [7:0] sh;
  logic bufWe;
  logic [7:0] bufIdx;
  logic [7:0] progIdx;
  logic [23:0] erA;

  always_comb begin
    s_nxt = s_r;
    s_nxt.progStb = 1'b0;
    s_nxt.erStb = 1'b0;
    s_nxt.csS = {s_r.csS[1:0], chipSelN};
    csNew = (s_r.csS[1] == s_r.csS[2]) ? s_r.csS[2] : s_r.csHigh;
    s_nxt.csHigh = csNew;
    s_nxt.tgS = {s_r.tgS[2:0], lk_r.tgl};
    bitEv = !s_r.csHigh && s_r.tgS[2] == s_r.tgS[3] &&
            s_r.tgS[3] != s_r.tgPrev;
    if (s_r.csHigh || bitEv) begin
      s_nxt.tgPrev = s_r.tgS[3];
    end
    frameEnd = !s_r.csHigh && csNew;
    sh = {s_r.shf[6:0], lk_r.din};
    bufWe = 1'b0;
    bufIdx = s_r.adr[7:0] + 8'(s_r.byteCnt - BYTES_ADDR_CMD);
    progIdx = s_r.adr[7:0] + s_r.step[7:0];
    good = 1'b0;
    erA = 24'h00_0000;
    // [R10] new frame at select fall
    if (s_r.csHigh && !csNew) begin
      s_nxt.bitIdx = 3'h0;
      s_nxt.byteCnt = 10'h000;
      s_nxt.skip = s_r.mode == SFCP_BUSY;
      if (s_r.mode != SFCP_BUSY) begin
        s_nxt.pgCnt = 9'h000;
      end
    end
    if (bitEv) begin
      s_nxt.shf = sh;
      s_nxt.bitIdx = s_r.bitIdx + 3'h1;
      if (s_r.bitIdx == 3'h7 && !s_r.skip) begin
        if (s_r.byteCnt == 10'h000) begin
          s_nxt.opc = sh;
        end else if (s_r.byteCnt < BYTES_ADDR_CMD) begin
          s_nxt.adr = {s_r.adr[15:0], sh};
        end
        if (s_r.byteCnt == BYTES_OPONLY) begin
          s_nxt.dat = sh;
        end
        // [R03] page buffer, wraps in page
        if (s_r.opc == OP_PAGE_PROGRAM && s_r.byteCnt >= BYTES_ADDR_CMD) begin
          bufWe = 1'b1;
          if (s_r.pgCnt != PAGE_BYTES) begin
            s_nxt.pgCnt = s_r.pgCnt + 9'h001;
          end
        end
      end
      if (s_r.bitIdx == 3'h7 && s_r.byteCnt != BYTES_SAT) begin
        s_nxt.byteCnt = s_r.byteCnt + 10'h001;
      end
    end
    // [R25] busy until count expires
    if (s_r.mode == SFCP_BUSY) begin
      s_nxt.busyCnt = s_r.busyCnt - 16'h0001;
      if (s_r.job == SFCP_JOB_PROG && s_r.step < s_r.pgCnt) begin
        s_nxt.progStb = 1'b1;
        s_nxt.progAdr = {s_r.adr[23:8], progIdx};
        s_nxt.progDat = pgBuf[progIdx];
        s_nxt.step = s_r.step + 9'h001;
      end
      if (s_r.busyCnt == 16'h0001) begin
        s_nxt.mode = SFCP_IDLE;
        // [R24] latch cleared after cycle
        s_nxt.write_enable_latch = 1'b0;
      end
    end
    if (frameEnd && !s_r.skip && s_r.byteCnt != 10'h000) begin
      // [R13] byte boundary and [R24] latch
      good = s_r.bitIdx == 3'h0 && s_r.write_enable_latch;
      // [R08] wake leaves deep sleep
      if (s_r.mode == SFCP_SLEEP) begin
        // [R09] all else ignored
        if (s_r.opc == OP_WAKE_ID) begin
          s_nxt.mode = SFCP_IDLE;
        end
      end else if (s_r.mode == SFCP_IDLE) begin
        s_nxt.busyCnt = BUSY_LOAD;
        s_nxt.step = 9'h000;
        case (s_r.opc)
          // [R15] latch set and clear
          OP_WRITE_ENABLE: s_nxt.write_enable_latch = 1'b1;
          OP_WRITE_DISABLE: s_nxt.write_enable_latch = 1'b0;
          OP_DEEP_SLEEP: s_nxt.mode = SFCP_SLEEP;
          // [R17] status write, one data byte
          OP_STATUS_WRITE: begin
            if (good && s_r.byteCnt == BYTES_STATUS_WR) begin
              s_nxt.bp = s_r.dat[SR_BP_LSB +: 3];
              s_nxt.srp = s_r.dat[SR_SRP_POS];
              s_nxt.mode = SFCP_BUSY;
              s_nxt.job = SFCP_JOB_STATUS;
            end
          end
          // [R26] protected program refused, [R27] no cycle
          OP_PAGE_PROGRAM: begin
            if (good && s_r.byteCnt >= BYTES_PROG_MIN &&
                !isProt(s_r.bp, s_r.adr)) begin
              s_nxt.mode = SFCP_BUSY;
              s_nxt.job = SFCP_JOB_PROG;
            end
          end
          // [R18] sector and block erase
          OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE: begin
            if (s_r.opc == OP_SECTOR_ERASE) begin
              erA = s_r.adr & SECTOR_MASK;
              s_nxt.erKind = SFCP_ER_SECTOR;
            end else if (s_r.opc == OP_BLOCK32_ERASE) begin
              erA = s_r.adr & BLOCK32_MASK;
              s_nxt.erKind = SFCP_ER_BLOCK32;
            end else begin
              erA = s_r.adr & BLOCK64_MASK;
              s_nxt.erKind = SFCP_ER_BLOCK64;
            end
            // [R26] scope overlapping region refused
            if (good && s_r.byteCnt == BYTES_ADDR_CMD &&
                !isProt(s_r.bp, erA)) begin
              // [R05] erase pulse starts cycle
              s_nxt.erStb = 1'b1;
              s_nxt.erAdr = erA;
              s_nxt.mode = SFCP_BUSY;
              s_nxt.job = SFCP_JOB_ERASE;
            end else begin
              s_nxt.erKind = s_r.erKind;
            end
          end
          // [R18] chip erase, two opcodes
          OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
            if (good && s_r.byteCnt == BYTES_OPONLY && s_r.bp == BP_RST) begin
              s_nxt.erStb = 1'b1;
              s_nxt.erAdr = 24'h00_0000;
              s_nxt.erKind = SFCP_ER_CHIP;
              s_nxt.mode = SFCP_BUSY;
              s_nxt.job = SFCP_JOB_ERASE;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.csS <= 3'b111;
      s_r.csHigh <= 1'b1;
      s_r.mode <= SFCP_IDLE;
      s_r.job <= SFCP_JOB_STATUS;
      s_r.bp <= BP_RST;
      s_r.srp <= SRP_RST;
      s_r.write_enable_latch <= WEL_RST;
      s_r.erKind <= SFCP_ER_SECTOR;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (bufWe) begin
      pgBuf[bufIdx] <= sh;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    statusWord = 8'h00;
    // [R06] status byte for polling
    statusWord[SR_SRP_POS] = s_r.srp;
    statusWord[SR_BP_LSB +: 3] = s_r.bp;
    statusWord[SR_WEL_POS] = s_r.write_enable_latch;
    statusWord[SR_BUSY_POS] = s_r.mode == SFCP_BUSY;
  end

  assign readOk = s_r.mode == SFCP_IDLE;
  assign statusOk = s_r.mode != SFCP_SLEEP;
  assign progStrobe = s_r.progStb;
  assign progAddr = s_r.progAdr;
  assign progData = s_r.progDat;
  assign eraseStrobe = s_r.erStb;
  assign eraseAddr = s_r.erAdr;
  assign eraseScope = s_r.erKind;
  assign inProgressFlag = s_r.mode == SFCP_BUSY;
  assign writeEnableLatch = s_r.write_enable_latch;
  assign protectCode = s_r.bp;
  assign deepSleep = s_r.mode == SFCP_SLEEP;
  // [R07] active while selected or busy
  assign deviceActive = !s_r.csHigh || s_r.mode == SFCP_BUSY;

endmodule

`default_nettype wire

// ### rtl/sfcp_pkg.sv
`default_nettype none
package sfcp_pkg;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_DUAL_READ = 8'h3B;
  localparam logic [7:0] OP_UNIQUE_ID = 8'h4B;
  localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_WAKE_ID = 8'hAB;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;

  // ****************************************
  // Array geometry
  // ****************************************
  localparam logic [23:0] ARRAY_BYTES_4M = 24'h08_0000;
  localparam logic [23:0] ARRAY_BYTES_2M = 24'h04_0000;
  localparam logic [23:0] SECTOR_MASK = 24'hFF_F000;
  localparam logic [23:0] BLOCK32_MASK = 24'hFF_8000;
  localparam logic [23:0] BLOCK64_MASK = 24'hFF_0000;
  localparam logic [8:0] PAGE_BYTES = 9'h100;

  // ****************************************
  // Status byte layout and reset values
  // ****************************************
  localparam int SR_BUSY_POS = 0;
  localparam int SR_WEL_POS = 1;
  localparam int SR_BP_LSB = 2;
  localparam int SR_SRP_POS = 7;
  localparam logic [2:0] BP_RST = 3'h0;
  localparam logic SRP_RST = 1'b0;
  localparam logic WEL_RST = 1'b0;

  // ****************************************
  // Frame lengths
  // ****************************************
  localparam logic [6:0] HDR_OPCODE = 7'h08;
  localparam logic [6:0] HDR_ADDR = 7'h20;
  localparam logic [6:0] HDR_DUMMY = 7'h28;
  localparam logic [6:0] CNT_SAT = 7'h7F;
  localparam logic [9:0] BYTES_OPONLY = 10'h001;
  localparam logic [9:0] BYTES_STATUS_WR = 10'h002;
  localparam logic [9:0] BYTES_ADDR_CMD = 10'h004;
  localparam logic [9:0] BYTES_PROG_MIN = 10'h005;
  localparam logic [9:0] BYTES_SAT = 10'h3FF;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    SFCP_IDLE = 3'b001,
    SFCP_BUSY = 3'b010,
    SFCP_SLEEP = 3'b100
  } sfcp_mode_t;

  typedef enum logic [2:0] {
    SFCP_JOB_STATUS = 3'b001,
    SFCP_JOB_PROG = 3'b010,
    SFCP_JOB_ERASE = 3'b100
  } sfcp_job_t;

  typedef enum logic [1:0] {
    SFCP_ER_SECTOR = 2'h0,
    SFCP_ER_BLOCK32 = 2'h1,
    SFCP_ER_BLOCK64 = 2'h2,
    SFCP_ER_CHIP = 2'h3
  } sfcp_erase_t;

endpackage
`default_nettype wire

// ### dv/sfcp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host side of the serial link
// ****************************************
module sfcp_host_model (
  output logic serialClk,
  output logic chipSelN,
  output logic hostLine0,
  input wire logic lineZero,
  input wire logic lineOne
);
  // Select edge at start clears link logic
  initial begin
    serialClk = 1'b0;
    chipSelN = 1'b0;
    hostLine0 = 1'b0;
    #1;
    chipSelN = 1'b1;
  end
  // Clock runs only inside a frame
  task automatic frame(input logic [63:0] tx, input int n,
    output logic [63:0] rx1, output logic [63:0] rx0);
    rx1 = '0;
    rx0 = '0;
    #3;
    chipSelN = 1'b0;
    for (int i = 0; i < n; i++) begin
      // bit set up before rise, MSB first
      hostLine0 = tx[63-i];
      #32;
      serialClk = 1'b1;
      rx1 = {rx1[62:0], lineOne};
      rx0 = {rx0[62:0], lineZero};
      #32;
      serialClk = 1'b0;
    end
    #32;
    // frame may close after any bit
    chipSelN = 1'b1;
    hostLine0 = ~hostLine0;
    #200;
  endtask
endmodule
`default_nettype wire

// ### dv/sfcp_core_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module sfcp_core_props
  import sfcp_pkg::*;
#(
  parameter bit IS_4MBIT = 1'b1,
  parameter int BUSY_CYCLES = 1000
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic chipSelN,
  input wire logic dualLineZeroOe,
  input wire logic dualLineOneOe,
  input wire logic progStrobe,
  input wire logic [23:0] progAddr,
  input wire logic eraseStrobe,
  input wire logic [23:0] eraseAddr,
  input wire sfcp_pkg::sfcp_erase_t eraseScope,
  input wire logic inProgressFlag,
  input wire logic writeEnableLatch,
  input wire logic [2:0] protectCode,
  input wire logic deepSleep,
  input wire logic deviceActive
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic [15:0] busyCnt_r;
  function automatic logic [23:0] topProt(input logic [2:0] c);
    case (c)
      3'h1: return 24'h07_DFFF;
      3'h2: return 24'h07_BFFF;
      3'h3: return 24'h07_7FFF;
      3'h4: return 24'h06_FFFF;
      3'h5: return 24'h05_FFFF;
      3'h6: return 24'h03_FFFF;
      default: return 24'h07_FFFF;
    endcase
  endfunction
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !inProgressFlag) begin
      busyCnt_r <= '0;
    end else begin
      busyCnt_r <= busyCnt_r + 16'h0001;
    end
  end
  prog_in_cycle_a: assert property (progStrobe |-> ##[0:1] inProgressFlag)
    else $error("program outside cycle");
  write_needs_latch_a: assert property ((progStrobe || eraseStrobe) |-> writeEnableLatch)
    else $error("write without latch");
  busy_length_a: assert property ($fell(inProgressFlag) |->
    busyCnt_r >= 16'(BUSY_CYCLES - 1) && busyCnt_r <= 16'(BUSY_CYCLES + 1))
    else $error("cycle length wrong");
  latch_end_a: assert property ($fell(inProgressFlag) |-> ##[0:2] !writeEnableLatch)
    else $error("latch kept after cycle");
  sleep_quiet_a: assert property (deepSleep |-> !progStrobe && !eraseStrobe && !dualLineOneOe)
    else $error("activity in deep sleep");
  sleep_entry_a: assert property ($rose(deepSleep) |-> chipSelN)
    else $error("sleep entered mid frame");
  select_active_a: assert property ($fell(chipSelN) |-> ##[1:4] deviceActive)
    else $error("not active when selected");
  busy_active_a: assert property (inProgressFlag |-> deviceActive)
    else $error("standby during cycle");
  standby_idle_a: assert property (chipSelN [*5] ##0 !inProgressFlag |-> !deviceActive)
    else $error("active while idle and deselected");
  dual_pair_a: assert property (dualLineZeroOe |-> dualLineOneOe)
    else $error("line zero alone driven");
  deselect_quiet_a: assert property (chipSelN |-> !dualLineOneOe && !dualLineZeroOe)
    else $error("driving while deselected");
  page_wrap_a: assert property (progStrobe ##1 progStrobe |->
    progAddr[23:8] == $past(progAddr[23:8]) &&
    progAddr[7:0] == $past(progAddr[7:0]) + 8'h01)
    else $error("program left its page");
  protect_map_a: assert property (IS_4MBIT && progStrobe && protectCode != 3'h0 |->
    progAddr > topProt(protectCode))
    else $error("protected address written");
  chip_scope_a: assert property (eraseStrobe && eraseScope == SFCP_ER_CHIP |->
    eraseAddr == 24'h00_0000 && protectCode == 3'h0)
    else $error("chip erase scope wrong");
  cover property (progStrobe ##1 progStrobe);
  cover property (eraseStrobe && eraseScope == SFCP_ER_CHIP);
  cover property ($rose(deepSleep));
endmodule
bind sfcp_core sfcp_core_props #(.IS_4MBIT(IS_4MBIT), .BUSY_CYCLES(BUSY_CYCLES))
  i_props (.clk_sys(clk_sys), .reset_n(reset_n), .chipSelN(chipSelN),
  .dualLineZeroOe(dualLineZeroOe), .dualLineOneOe(dualLineOneOe),
  .progStrobe(progStrobe), .progAddr(progAddr), .eraseStrobe(eraseStrobe),
  .eraseAddr(eraseAddr), .eraseScope(eraseScope),
  .inProgressFlag(inProgressFlag), .writeEnableLatch(writeEnableLatch),
  .protectCode(protectCode), .deepSleep(deepSleep),
  .deviceActive(deviceActive));
`default_nettype wire

// ### dv/test_serial_flash_command_protect.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin \
  miscompares++; $display("Error t=%0t got %0h exp %0h", $time, g, e); end end
module test_serial_flash_command_protect;
  import sfcp_pkg::*;
  logic clk_sys, reset_n, serialClk, chipSelN, serialIn, hostLine0, lineOne;
  logic dualLineZeroOut, dualLineZeroOe, dualLineOne, dualLineOneOe;
  logic tgl = 1'b0;
  logic progStrobe, eraseStrobe, inProgressFlag, writeEnableLatch;
  logic deepSleep, deviceActive, oeSeen;
  logic [23:0] rdAddr, progAddr, eraseAddr, lastAddr, lastEAddr;
  logic [7:0] rdData, progData, lastData;
  logic [2:0] protectCode;
  sfcp_erase_t eraseScope, lastScope;
  logic [63:0] r1, r0;
  int miscompares = 0, nCompared = 0, nProg = 0, nErase = 0, nRise = 0;
  localparam logic [7:0] E_OP [5] = '{OP_SECTOR_ERASE, OP_BLOCK32_ERASE,
    OP_BLOCK64_ERASE, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
  localparam logic [23:0] E_AD [5] = '{24'h04_5000, 24'h04_0000,
    24'h04_0000, 24'h00_0000, 24'h00_0000};
  sfcp_core #(.BUSY_CYCLES(300)) i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .serialClk(serialClk), .chipSelN(chipSelN), .serialIn(serialIn),
    .dualLineZeroOut(dualLineZeroOut), .dualLineZeroOe(dualLineZeroOe),
    .dualLineOne(dualLineOne), .dualLineOneOe(dualLineOneOe),
    .rdAddr(rdAddr), .rdData(rdData), .progStrobe(progStrobe),
    .progAddr(progAddr), .progData(progData), .eraseStrobe(eraseStrobe),
    .eraseAddr(eraseAddr), .eraseScope(eraseScope),
    .inProgressFlag(inProgressFlag), .writeEnableLatch(writeEnableLatch),
    .protectCode(protectCode), .deepSleep(deepSleep),
    .deviceActive(deviceActive));
  sfcp_host_model i_host (.serialClk(serialClk), .chipSelN(chipSelN),
    .hostLine0(hostLine0), .lineZero(serialIn), .lineOne(lineOne));
  // Undriven output line shows a changing pattern
  assign serialIn = dualLineZeroOe ? dualLineZeroOut : hostLine0;
  assign lineOne = dualLineOneOe ? dualLineOne : tgl;
  assign rdData = rdAddr[7:0] ^ 8'h5A;
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    tgl <= ~tgl;
    if (progStrobe === 1'b1) begin
      nProg++;
      lastAddr = progAddr;
      lastData = progData;
    end
    if (eraseStrobe === 1'b1) begin
      nErase++;
      lastEAddr = eraseAddr;
      lastScope = eraseScope;
    end
  end
  always @(posedge inProgressFlag) nRise++;
  always @(posedge dualLineOneOe) oeSeen = 1'b1;
  task automatic cmd(input logic [63:0] tx, input int n);
    i_host.frame(tx, n, r1, r0);
  endtask
  task automatic op(input logic [7:0] o, input int n);
    cmd({o, 56'h0}, n);
  endtask
  task automatic waitIdle();
    for (int i = 0; i < 400 && inProgressFlag !== 1'b0; i++) @(negedge clk_sys);
    `CHK(inProgressFlag, 1'b0)
  endtask
  task automatic wr(input logic [63:0] tx, input int n);
    op(OP_WRITE_ENABLE, 8);
    cmd(tx, n);
    waitIdle();
  endtask
  task automatic tdone(input string s);
    $display("Test %s done", s);
  endtask
  task automatic final_report();
    $display("Compared %0d, miscompares %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #800_000;
    miscompares++;
    final_report();
  end
  initial begin
    reset_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    `CHK({inProgressFlag, writeEnableLatch, protectCode, deepSleep, deviceActive}, 7'h00)
    op(OP_WRITE_ENABLE, 8);
    op(OP_READ_STATUS, 24);
    `CHK(r1[15:0], 16'h0202)
    op(OP_WRITE_DISABLE, 8);
    op(OP_READ_STATUS, 16);
    `CHK(r1[7:0], 8'h00)
    tdone("latch");
    op(OP_WRITE_ENABLE, 8);
    cmd({OP_STATUS_WRITE, 8'h18, 48'h0}, 16);
    op(OP_READ_STATUS, 16);
    `CHK(r1[7:0], 8'h1B)
    op(OP_WRITE_ENABLE, 8);
    waitIdle();
    op(OP_READ_STATUS, 16);
    `CHK(r1[7:0], 8'h18)
    `CHK(protectCode, 3'h6)
    tdone("status write");
    wr({OP_PAGE_PROGRAM, 24'h01_0000, 8'h12, 24'h0}, 40);
    `CHK({nRise, nProg}, {32'd1, 32'd0})
    `CHK(writeEnableLatch, 1'b1)
    wr({OP_PAGE_PROGRAM, 24'h04_00FF, 16'hA53C, 16'h0}, 48);
    `CHK(nProg, 2)
    `CHK({lastAddr, lastData}, 32'h0400_003C)
    wr({OP_CHIP_ERASE_B, 56'h0}, 8);
    `CHK(nErase, 0)
    wr({OP_STATUS_WRITE, 56'h0}, 16);
    tdone("protect");
    for (int i = 0; i < 5; i++) begin
      wr({E_OP[i], 24'h04_5678, 32'h0}, i < 3 ? 32 : 8);
      `CHK(nErase, i + 1)
      `CHK({lastEAddr, lastScope}, {E_AD[i], i < 3 ? 2'(i) : 2'h3})
    end
    wr({OP_SECTOR_ERASE, 24'h04_5678, 32'h0}, 35);
    `CHK(nErase, 5)
    op(OP_WRITE_DISABLE, 8);
    cmd({OP_SECTOR_ERASE, 24'h04_5678, 32'h0}, 32);
    `CHK(nErase, 5)
    tdone("erase");
    cmd({OP_READ, 24'h00_01FE, 32'h0}, 48);
    `CHK(r1[15:0], 16'hA4A5)
    cmd({OP_FAST_READ, 24'h00_0010, 32'h0}, 48);
    `CHK(r1[7:0], 8'h4A)
    cmd({OP_DUAL_READ, 24'h00_0010, 32'h0}, 44);
    `CHK({r1[3:0], r0[3:0]}, 8'h38)
    op(OP_UNIQUE_ID, 64);
    `CHK(r1[23:0], 24'h01_2345)
    op(OP_WRITE_ENABLE, 8);
    op(OP_STATUS_WRITE, 16);
    oeSeen = 1'b0;
    op(OP_READ, 40);
    `CHK(oeSeen, 1'b0)
    waitIdle();
    tdone("read");
    op(OP_DEEP_SLEEP, 8);
    `CHK(deepSleep, 1'b1)
    oeSeen = 1'b0;
    op(OP_WRITE_ENABLE, 8);
    op(OP_READ_STATUS, 16);
    `CHK({oeSeen, writeEnableLatch}, 2'b00)
    op(OP_WAKE_ID, 8);
    `CHK({deepSleep, deviceActive}, 2'b00)
    tdone("sleep");
    final_report();
  end
endmodule
`default_nettype wire
